/* File: rtl/fesf_consts.vh */
`ifndef FESF_CONSTS_VH
`define FESF_CONSTS_VH

// exception classes presented by the core
`define FESF_CLS_SIG_NAN     3'h0
`define FESF_CLS_OPND_ERR    3'h1
`define FESF_CLS_OVERFLOW    3'h2
`define FESF_CLS_UNDERFLOW   3'h3
`define FESF_CLS_DIV_ZERO    3'h4

// instruction groups for overflow and underflow
`define FESF_GRP_REGMOVE     2'h0
`define FESF_GRP_MEMMOVE     2'h1
`define FESF_GRP_ARITH       2'h2

// opclass field of the command word
`define FESF_OPCLASS_HI      15
`define FESF_OPCLASS_LO      13
`define FESF_OPCLASS_000     3'h0
`define FESF_OPCLASS_010     3'h2
`define FESF_OPCLASS_011     3'h3

// operand tag encodings
`define FESF_TAG_NORM        3'h0
`define FESF_TAG_ZERO        3'h1
`define FESF_TAG_INF         3'h2
`define FESF_TAG_NAN         3'h3
`define FESF_TAG_XDEN        3'h4
`define FESF_TAG_SDDEN       3'h5

// extended operand layout: sign 79, exponent 78..64, mantissa 63..0
`define FESF_SIGNAL_BIT      62
`define FESF_EXP_MSB         15

// register byte offsets
`define FESF_REG_CTRL        8'h00
`define FESF_REG_STATUS      8'h04
`define FESF_REG_MASK        8'h08
`define FESF_REG_INFO        8'h0C
`define FESF_REG_CMD         8'h10

// ctrl bits and reset value
`define FESF_CTRL_ENABLE     0
`define FESF_CTRL_RESET      32'h0000_0001

// status and mask bit positions
`define FESF_ST_SIG_NAN      0
`define FESF_ST_OPND_ERR     1
`define FESF_ST_OVERFLOW     2
`define FESF_ST_UNDERFLOW    3
`define FESF_ST_DIV_ZERO     4
`define FESF_ST_DROP         5
`define FESF_ST_WIDTH        6
`define FESF_MASK_RESET      6'h00

`endif

/* File: rtl/fesf_frame.v */
`timescale 1ns/100ps
`include "fesf_consts.vh"

module fesf_frame (
   // clock and reset
   input  wire        pclk,
   input  wire        presetn,
   // apb slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   output reg         irq,
   // exception report from the core, same clock
   input  wire        exc_valid,
   input  wire [2:0]  exc_class,
   input  wire [1:0]  exc_group,
   input  wire [15:0] cmd_word,
   input  wire [15:0] cmd_encoded,
   input  wire [79:0] src_operand,
   input  wire [2:0]  src_tag,
   input  wire [79:0] dst_operand,
   input  wire [2:0]  dst_tag,
   input  wire [79:0] rounded_result,
   input  wire [79:0] unrounded_result,
   input  wire        int_sign,
   input  wire [14:0] int_exponent,
   input  wire [66:0] int_mantissa,
   input  wire        int_sticky,
   input  wire [31:0] rounded_integer,
   // frame release
   input  wire        state_saved,
   input  wire        frame_restored,
   // saved frame
   output reg         frame_valid,
   output reg  [15:0] saved_command_word,
   output reg  [15:0] encoded_command_word,
   output reg  [79:0] exception_operand_temp,
   output reg  [2:0]  source_operand_tag,
   output reg  [2:0]  dest_operand_tag,
   output reg  [79:0] destination_temp,
   output reg         writeback_sign,
   output reg  [15:0] writeback_exponent,
   output reg  [66:0] writeback_mantissa,
   output reg         sticky_bit,
   output reg         stage_one_flag,
   output reg         stage_three_flag,
   output reg         post_flag
);

   // opclass of a command word, used for move-out decode and post flag
   function [2:0] opclass_of;
      input [15:0] cw;
      begin
         opclass_of = cw[`FESF_OPCLASS_HI:`FESF_OPCLASS_LO];
      end
   endfunction

   // one-hot status bit for an exception class
   function [`FESF_ST_WIDTH-1:0] class_bit;
      input [2:0] cls;
      begin
         class_bit = {`FESF_ST_WIDTH{1'b0}};
         case (cls)
            `FESF_CLS_SIG_NAN:   class_bit[`FESF_ST_SIG_NAN] = 1'b1;
            `FESF_CLS_OPND_ERR:  class_bit[`FESF_ST_OPND_ERR] = 1'b1;
            `FESF_CLS_OVERFLOW:  class_bit[`FESF_ST_OVERFLOW] = 1'b1;
            `FESF_CLS_UNDERFLOW: class_bit[`FESF_ST_UNDERFLOW] = 1'b1;
            `FESF_CLS_DIV_ZERO:  class_bit[`FESF_ST_DIV_ZERO] = 1'b1;
            default:         class_bit = {`FESF_ST_WIDTH{1'b0}};
         endcase
      end
   endfunction

   reg  [31:0]               ctrl;
   reg  [`FESF_ST_WIDTH-1:0] status;
   reg  [`FESF_ST_WIDTH-1:0] mask;
   reg  [2:0]                held_class;

   wire [2:0] opc        = opclass_of(cmd_word);
   wire       move_out   = (opc == `FESF_OPCLASS_011);
   wire       capture_en = ctrl[`FESF_CTRL_ENABLE];
   // a new report while a frame is held is dropped, never merged
   wire       take       = exc_valid & capture_en & ~frame_valid;
   wire       dropped    = exc_valid & capture_en & frame_valid;

   // next frame contents, chosen by class and instruction group
   // stage and post-instruction flags
   reg        next_first_stage;
   reg        next_third_stage;
   reg        next_t;
   // command words
   reg [15:0] next_cmd1;
   reg [15:0] next_cmd3;
   // operand images and their tags
   reg [79:0] next_operand_img;
   reg [2:0]  next_src_tag;
   reg [2:0]  next_dst_tag;
   reg [79:0] next_dest_img;
   // writeback image, used by stage-three frames and by operand-error move-outs
   reg        next_wb_sign;
   reg [15:0] next_wb_exp;
   reg [66:0] next_wb_mant;
   reg        next_sticky;

   // defaults describe a plain stage-one frame; each class overrides
   // only the fields it owns, so fields a class leaves alone save as
   // their defaults (zero, or the source tag and command word) and never leak data from an older frame into the handler
   always @* begin
      next_first_stage = 1'b1;
      next_third_stage = 1'b0;
      next_t           = 1'b0;
      next_cmd1        = cmd_word;
      next_cmd3        = 16'h0000;
      next_operand_img = 80'h0;
      next_src_tag     = src_tag;
      next_dst_tag     = `FESF_TAG_NORM;
      next_dest_img    = 80'h0;
      next_wb_sign     = 1'b0;
      next_wb_exp      = 16'h0000;
      next_wb_mant     = 67'h0;
      next_sticky      = 1'b0;
      case (exc_class)
         // signalling nan: a move-out keeps only the source image, the
         // other opclasses keep the destination as well
         `FESF_CLS_SIG_NAN: begin
            next_operand_img = src_operand;
            if (move_out) begin
               // the saved image must still look signalling
               next_operand_img[`FESF_SIGNAL_BIT] = 1'b1;
               next_src_tag = `FESF_TAG_NAN;
               next_t       = 1'b1;
            end else begin
               next_dest_img = dst_operand;
               next_dst_tag  = dst_tag;
            end
         end
         // operand error: a move-out also hands over the rounded integer,
         // so the handler can tell a real integer overflow from a false one
         `FESF_CLS_OPND_ERR: begin
            next_operand_img = src_operand;
            if (move_out) begin
               next_wb_mant = {35'h0, rounded_integer};
               next_t       = 1'b1;
            end else begin
               next_dest_img = dst_operand;
               next_dst_tag  = dst_tag;
            end
         end
         // overflow: arithmetic results go to the writeback image in
         // stage three, moves to the destination image in stage one
         `FESF_CLS_OVERFLOW: begin
            if (exc_group == `FESF_GRP_ARITH) begin
               next_first_stage = 1'b0;
               next_third_stage = 1'b1;
               next_cmd3        = cmd_encoded;
               next_wb_sign     = rounded_result[79];
               // top exponent bit low tells the handler this was overflow
               next_wb_exp      = {1'b0, rounded_result[78:64]};
               // rounded value carries no guard or round bits
               next_wb_mant     = {1'b0, rounded_result[63:0], 2'b00};
            end else begin
               next_dest_img = rounded_result;
               next_src_tag  = `FESF_TAG_NORM;
               next_t        = (exc_group == `FESF_GRP_MEMMOVE);
            end
         end
         // underflow: in arithmetic frames the writeback image keeps the unrounded mantissa
         // with guard and round in its two lowest bits
         `FESF_CLS_UNDERFLOW: begin
            if (exc_group == `FESF_GRP_ARITH) begin
               next_first_stage = 1'b0;
               next_third_stage = 1'b1;
               next_cmd3        = cmd_encoded;
               next_wb_sign     = int_sign;
               next_wb_exp      = {1'b1, int_exponent};
               next_wb_mant     = int_mantissa;
               next_sticky      = int_sticky;
            end else begin
               next_dest_img = unrounded_result;
               next_src_tag  = `FESF_TAG_NORM;
               next_t        = (exc_group == `FESF_GRP_MEMMOVE);
            end
         end
         // divide by zero: both operands, source tag from the default
         `FESF_CLS_DIV_ZERO: begin
            next_operand_img = src_operand;
            next_dest_img    = dst_operand;
         end
         // spare class codes save a bare stage-one frame; the info word
         // still shows the raw class so software can spot them
         default: begin
            next_first_stage = 1'b1;
         end
      endcase
   end

   // frame store: loaded once, frozen until saved or restored
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frame_valid            <= 1'b0;
         held_class             <= 3'h0;
         saved_command_word     <= 16'h0000;
         encoded_command_word   <= 16'h0000;
         exception_operand_temp <= 80'h0;
         source_operand_tag     <= 3'h0;
         dest_operand_tag       <= 3'h0;
         destination_temp       <= 80'h0;
         writeback_sign         <= 1'b0;
         writeback_exponent     <= 16'h0000;
         writeback_mantissa     <= 67'h0;
         sticky_bit             <= 1'b0;
         stage_one_flag         <= 1'b0;
         stage_three_flag       <= 1'b0;
         post_flag              <= 1'b0;
      end else if (take) begin
         frame_valid            <= 1'b1;
         held_class             <= exc_class;
         saved_command_word     <= next_cmd1;
         encoded_command_word   <= next_cmd3;
         exception_operand_temp <= next_operand_img;
         source_operand_tag     <= next_src_tag;
         dest_operand_tag       <= next_dst_tag;
         destination_temp       <= next_dest_img;
         writeback_sign         <= next_wb_sign;
         writeback_exponent     <= next_wb_exp;
         writeback_mantissa     <= next_wb_mant;
         sticky_bit             <= next_sticky;
         stage_one_flag         <= next_first_stage;
         stage_three_flag       <= next_third_stage;
         post_flag              <= next_t;
      end else if (state_saved | frame_restored) begin
         // only the valid bit drops; the contents stay readable so a
         // handler that restores late still sees what was saved
         frame_valid            <= 1'b0;
      end
   end

   // apb access phase decode
   wire        acc     = psel & penable & ~pready;
   wire        wr      = acc & pwrite;
   wire        mapped  = (paddr == `FESF_REG_CTRL) | (paddr == `FESF_REG_STATUS) |
                         (paddr == `FESF_REG_MASK) | (paddr == `FESF_REG_INFO) |
                         (paddr == `FESF_REG_CMD);
   wire [`FESF_ST_WIDTH-1:0] events = (take ? class_bit(exc_class) :
                                       {`FESF_ST_WIDTH{1'b0}}) |
                                      ({`FESF_ST_WIDTH{dropped}} &
                                       (6'h01 << `FESF_ST_DROP));
   wire [`FESF_ST_WIDTH-1:0] w1c    = (wr && paddr == `FESF_REG_STATUS) ?
                                      pwdata[`FESF_ST_WIDTH-1:0] :
                                      {`FESF_ST_WIDTH{1'b0}};
   // new event beats a clear in the same cycle
   wire [`FESF_ST_WIDTH-1:0] next_status = (status & ~w1c) | events;

   // info word: class, tags and flags of the held frame, read only
   wire [31:0] info_word = {16'h0000,   // unused upper half
                            1'b0,       // spare
                            held_class,
                            source_operand_tag,
                            dest_operand_tag,
                            2'b00,      // spare
                            post_flag,
                            stage_three_flag,
                            stage_one_flag,
                            frame_valid};
   // command word pair, encoded word in the upper half
   wire [31:0] cmd_pair  = {encoded_command_word, saved_command_word};

   // read mux; unmapped places read zero and are flagged by pslverr
   reg  [31:0] rd_value;
   always @* begin
      case (paddr)
         `FESF_REG_CTRL:   rd_value = ctrl;
         `FESF_REG_STATUS: rd_value = {26'h0, status};
         `FESF_REG_MASK:   rd_value = {26'h0, mask};
         `FESF_REG_INFO:   rd_value = info_word;
         `FESF_REG_CMD:    rd_value = cmd_pair;
         default:          rd_value = 32'h0000_0000;
      endcase
   end

   // registers, one wait state on every access; the access is taken
   // while pready is low, so a held request is never taken twice
   // irq follows next_status so it rises with the status bit itself
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl    <= `FESF_CTRL_RESET;
         status  <= {`FESF_ST_WIDTH{1'b0}};
         mask    <= `FESF_MASK_RESET;
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
         irq     <= 1'b0;
      end else begin
         pready  <= acc;
         pslverr <= acc & ~mapped;
         prdata  <= (acc & ~pwrite) ? rd_value : 32'h0000_0000;
         status  <= next_status;
         irq     <= |(next_status & mask);
         if (wr && paddr == `FESF_REG_CTRL) begin
            ctrl <= {31'h0, pwdata[`FESF_CTRL_ENABLE]};
         end
         if (wr && paddr == `FESF_REG_MASK) begin
            mask <= pwdata[`FESF_ST_WIDTH-1:0];
         end
      end
   end

endmodule // fesf_frame

/* File: test/fesf_frame_monitor.sv */
`timescale 1ns/100ps
`include "fesf_consts.vh"
module fesf_frame_monitor (
   // clock, reset and bus
   input wire        pclk,
   input wire        presetn,
   input wire        psel,
   input wire        penable,
   input wire [7:0]  paddr,
   input wire        pready,
   input wire        pslverr,
   // core report and release
   input wire        exc_valid,
   input wire [2:0]  exc_class,
   input wire [1:0]  exc_group,
   input wire [15:0] cmd_word,
   input wire [14:0] int_exponent,
   input wire        int_sticky,
   input wire        state_saved,
   input wire        frame_restored,
   // saved frame
   input wire        frame_valid,
   input wire [15:0] saved_command_word,
   input wire [2:0]  source_operand_tag,
   input wire [15:0] writeback_exponent,
   input wire        sticky_bit,
   input wire        stage_one_flag,
   input wire        stage_three_flag,
   input wire        post_flag
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // bus request taken, and a frame just captured
   sequence s_taken;
      psel && penable && !pready;
   endsequence
   sequence s_capture;
      !frame_valid ##1 frame_valid;
   endsequence
   a_one_wait: assert property (s_taken |=> pready ##1 !pready)
      else $error("bus answer not a single pulse one cycle after request");
   a_err_unmapped: assert property (pready |-> pslverr == (paddr > 8'h10 || paddr[1:0] != 2'h0))
      else $error("error response does not match address map");
   a_take_cause: assert property (s_capture |-> $past(exc_valid))
      else $error("frame captured without a report");
   a_exp_msb: assert property (s_capture ##0 stage_three_flag |->
      writeback_exponent[15] == ($past(exc_class) == `FESF_CLS_UNDERFLOW))
      else $error("writeback exponent top bit wrong");
   a_underflow_fields: assert property (s_capture ##0 ($past(exc_class) == `FESF_CLS_UNDERFLOW &&
      $past(exc_group) == `FESF_GRP_ARITH) |-> sticky_bit == $past(int_sticky) &&
      writeback_exponent[14:0] == $past(int_exponent))
      else $error("underflow writeback fields wrong");
   a_move_tag: assert property (s_capture ##0 ($past(exc_class) inside {`FESF_CLS_OVERFLOW,
      `FESF_CLS_UNDERFLOW} && $past(exc_group) != `FESF_GRP_ARITH) |-> source_operand_tag == 3'h0)
      else $error("move frame source tag not normalized");
   a_post_only: assert property (s_capture |-> post_flag ==
      (($past(exc_class) <= `FESF_CLS_OPND_ERR && $past(cmd_word[15:13]) == 3'h3) ||
      ($past(exc_class) inside {`FESF_CLS_OVERFLOW, `FESF_CLS_UNDERFLOW} &&
      $past(exc_group) == `FESF_GRP_MEMMOVE)))
      else $error("post-instruction flag wrong");
   a_stage_excl: assert property (frame_valid |-> stage_one_flag != stage_three_flag)
      else $error("stage flags not exclusive");
   a_frame_hold: assert property (frame_valid && !state_saved && !frame_restored |=>
      frame_valid && $stable(saved_command_word))
      else $error("held frame changed");
   a_release: assert property (frame_valid && (state_saved || frame_restored) |=> !frame_valid)
      else $error("frame not released");
endmodule // fesf_frame_monitor

bind fesf_frame fesf_frame_monitor u_mon (.*);

/* File: test/fesf_core_model.sv */
`timescale 1ns/100ps
module fesf_core_model (
   // clock
   input wire          pclk,
   // exception report
   output logic        exc_valid,
   output logic [2:0]  exc_class,
   output logic [1:0]  exc_group,
   output logic [15:0] cmd_word,
   output logic [15:0] cmd_encoded,
   output logic [79:0] src_operand,
   output logic [2:0]  src_tag,
   output logic [79:0] dst_operand,
   output logic [2:0]  dst_tag,
   output logic [79:0] rounded_result,
   output logic [79:0] unrounded_result,
   output logic        int_sign,
   output logic [14:0] int_exponent,
   output logic [66:0] int_mantissa,
   output logic        int_sticky,
   output logic [31:0] rounded_integer,
   // handler release
   output logic        state_saved,
   output logic        frame_restored
);
   integer seed = 32'hC57CE34F;
   // quiet lines at time zero
   initial begin
      {exc_valid, exc_class, exc_group, cmd_word, state_saved, frame_restored} = '0;
   end
   // one report pulse with fresh random operands
   task automatic fire(input [2:0] c, input [1:0] g, input [15:0] cw);
      logic [479:0] r;
      for (int i = 0; i < 15; i++) r = {r[447:0], $random(seed)};
      @(posedge pclk);
      exc_valid <= 1'h1;
      exc_class <= c;
      exc_group <= g;
      cmd_word <= cw;
      {src_operand, dst_operand, rounded_result, unrounded_result, int_mantissa,
       rounded_integer, cmd_encoded, int_exponent, src_tag, dst_tag, int_sign,
       int_sticky} <= r[457:0];
      @(posedge pclk);
      exc_valid <= 1'h0;
      // scrambled once invalid, so a late capture shows up
      exc_class <= ~c;
      cmd_word <= ~cw;
   endtask
   // handler saves state or restores the frame, one-cycle pulse
   task automatic release_frame(input bit restore);
      @(posedge pclk);
      state_saved <= !restore;
      frame_restored <= restore;
      @(posedge pclk);
      state_saved <= 1'h0;
      frame_restored <= 1'h0;
   endtask
endmodule // fesf_core_model

/* File: test/fesf_frame_bench.sv */
`timescale 1ns/100ps
`include "fesf_consts.vh"
module fesf_frame_bench;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
   logic [7:0]  paddr = 0;
   logic [31:0] pwdata = 0, rd;
   logic [15:0] cw;
   wire  [31:0] prdata, rounded_integer;
   wire         pready, pslverr, irq, exc_valid, int_sign, int_sticky, state_saved;
   wire         frame_restored, frame_valid, writeback_sign, sticky_bit, post_flag;
   wire         stage_one_flag, stage_three_flag;
   wire  [2:0]  exc_class, src_tag, dst_tag, source_operand_tag, dest_operand_tag;
   wire  [1:0]  exc_group;
   wire  [15:0] cmd_word, cmd_encoded, saved_command_word, encoded_command_word;
   wire  [15:0] writeback_exponent;
   wire  [79:0] src_operand, dst_operand, rounded_result, unrounded_result;
   wire  [79:0] exception_operand_temp, destination_temp;
   wire  [14:0] int_exponent;
   wire  [66:0] int_mantissa, writeback_mantissa;
   int          error_cnt = 0, cmp_count = 0;
   // {class, group, opclass} of every frame kind but the spare classes
   logic [7:0]  cases [12] = '{8'h03, 8'h00, 8'h20, 8'h22, 8'h23, 8'h40, 8'h4B, 8'h50,
                               8'h60, 8'h6B, 8'h70, 8'h80};
   fesf_frame uut (.*);
   fesf_core_model core (.*);
   initial forever #4 pclk = ~pclk;
   task automatic chk(input logic [95:0] got, input logic [95:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task tally_and_finish;
      $display("compares %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // an edge passes first, so back-to-back calls never drive psel twice at once
   task automatic apb(input w, input [7:0] a, input [31:0] d);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'h0;
   endtask
   task automatic rd_chk(input [7:0] a, input [31:0] d, input e);
      apb(1'h0, a, 32'h0);
      chk(rd, d);
      chk(err, e);
   endtask
   // expected frame, worked out from the class, group and opclass
   task automatic check_frame(input [7:0] k, input [15:0] w);
      logic [2:0] c, oc;
      logic [1:0] g;
      logic       mv, ar;
      {c, g, oc} = k;
      mv = c == `FESF_CLS_OVERFLOW || c == `FESF_CLS_UNDERFLOW;
      ar = mv && g == `FESF_GRP_ARITH;
      chk(frame_valid, 1'h1);
      chk(saved_command_word, w);
      chk(encoded_command_word, ar ? cmd_encoded : 16'h0);
      // the handler picks the layout by the stage-three flag first
      chk({stage_three_flag, stage_one_flag}, ar ? 2'h2 : 2'h1);
      chk(post_flag, (c < 2 && oc == 3) || (mv && g == 1));
      if (!mv) chk(exception_operand_temp, src_operand | {17'h0, c == 0 && oc == 3, 62'h0});
      if (c == 0 && oc == 3) chk(source_operand_tag, `FESF_TAG_NAN);
      else if (mv && !ar) chk(source_operand_tag, `FESF_TAG_NORM);
      else if (!mv) chk(source_operand_tag, src_tag);
      if (mv && !ar) chk(destination_temp, c == 2 ? rounded_result : unrounded_result);
      if (!mv && oc != 3) chk(destination_temp, dst_operand);
      if (c < 2 && oc != 3) chk(dest_operand_tag, dst_tag);
      if (c == 1 && oc == 3) chk(writeback_mantissa[31:0], rounded_integer);
      if (ar && c == 2) chk({writeback_sign, writeback_exponent, writeback_mantissa},
         {rounded_result[79], 1'h0, rounded_result[78:64], 1'h0, rounded_result[63:0], 2'h0});
      if (ar && c == 3) chk({writeback_sign, writeback_exponent, writeback_mantissa, sticky_bit},
         {int_sign, 1'h1, int_exponent, int_mantissa, int_sticky});
   endtask
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'h1;
      // reset values and an unmapped place
      rd_chk(`FESF_REG_CTRL, `FESF_CTRL_RESET, 1'h0);
      rd_chk(`FESF_REG_MASK, 32'h0, 1'h0);
      rd_chk(`FESF_REG_STATUS, 32'h0, 1'h0);
      rd_chk(8'h14, 32'h0, 1'h1);
      $display("register reset test done");
      // every frame kind but the spare classes; mask open from the second one on
      foreach (cases[i]) begin
         cw = {cases[i][2:0], 5'(i), 8'hA5};
         core.fire(cases[i][7:5], cases[i][4:3], cw);
         repeat (2) @(posedge pclk);
         check_frame(cases[i], cw);
         chk(irq, i > 0);
         rd_chk(`FESF_REG_STATUS, 32'h1 << cases[i][7:5], 1'h0);
         rd_chk(`FESF_REG_CMD, {(cases[i][4:3] == 2'h2 && cases[i][7:6] == 2'h1) ?
                cmd_encoded : 16'h0, cw}, 1'h0);
         apb(1'h1, `FESF_REG_STATUS, 32'h3F);
         if (i == 0) apb(1'h1, `FESF_REG_MASK, 32'h3F);
         @(posedge pclk);
         chk(irq, 1'h0);
         core.release_frame(i[0]);
         @(posedge pclk);
         chk(frame_valid, 1'h0);
         $display("frame case %0d done", i);
      end
      // a second report while a frame is held is dropped
      core.fire(3'h0, 2'h0, 16'h6123);
      core.fire(3'h1, 2'h0, 16'h0456);
      repeat (2) @(posedge pclk);
      chk(saved_command_word, 16'h6123);
      rd_chk(`FESF_REG_STATUS, 32'h21, 1'h0);
      core.release_frame(1'h0);
      $display("drop test done");
      // capture switched off: a report is ignored and sets no status
      apb(1'h1, `FESF_REG_STATUS, 32'h3F);
      apb(1'h1, `FESF_REG_CTRL, 32'h0);
      core.fire(3'h4, 2'h0, 16'h0789);
      repeat (2) @(posedge pclk);
      chk(frame_valid, 1'h0);
      rd_chk(`FESF_REG_STATUS, 32'h0, 1'h0);
      $display("disable test done");
      tally_and_finish;
   end
   // cut a hang short
   initial begin
      repeat (20000) @(posedge pclk);
      error_cnt++;
      tally_and_finish;
   end
endmodule // fesf_frame_bench
